// File: hw/timer_and_ext_irq_control.sv
// Control register bank for two timers and two external interrupt inputs.
`timescale 1ns/1ps
module timer_and_ext_irq_control (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // APB slave.
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer datapath side.
    input wire logic timer0_rollover,
    input wire logic timer1_rollover,
    output logic timer0_run,
    output logic timer1_run,
    // External interrupt pins.
    input wire logic ext_irq0_input,
    input wire logic ext_irq1_input,
    // CPU vectoring side.
    input wire timer_irq_pkg::vector_ack_t vector_ack,
    output timer_irq_pkg::ctl_t ctl_flags,
    // Interrupt request.
    output logic irq
);

    timer_irq_pkg::ctl_t ctl_r;
    timer_irq_pkg::ctl_t ctl_nxt;
    logic [1:0] cfg_r;
    logic [3:0] status_r;
    logic [3:0] status_nxt;
    logic [3:0] mask_r;
    logic irq_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_data;
    logic rd_mapped;
    logic access;
    logic wr_en;
    logic wr_ctl;
    logic [3:0] events;
    logic [1:0] pin_in;
    logic [1:0] pol;
    logic [1:0] etype;
    logic [1:0] active;
    logic [1:0] ext_set;
    logic sync1_r [2];
    logic sync2_r [2];
    logic active_prev_r [2];

    // Address match, used by both the read and the write decode.
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] offset);
        hit = (addr == offset);
    endfunction : hit

    // APB handshake: one wait state, so the access phase lasts two cycles.
    assign access = psel & penable;
    assign wr_en = access & pready_r & pwrite;
    assign wr_ctl = wr_en & hit(paddr, timer_irq_pkg::ADDR_CTL);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pready_r <= 1'h0;
        end else begin
            pready_r <= access & ~pready_r;
        end
    end

    // Read mux; reserved bits above each register read as zero.
    always_comb begin
        rd_data = 32'h0;
        rd_mapped = 1'h1;
        if (hit(paddr, timer_irq_pkg::ADDR_CTL)) begin
            rd_data = {24'h0, ctl_r};
        end else if (hit(paddr, timer_irq_pkg::ADDR_CFG)) begin
            rd_data = {30'h0, cfg_r};
        end else if (hit(paddr, timer_irq_pkg::ADDR_STATUS)) begin
            rd_data = {28'h0, status_r};
        end else if (hit(paddr, timer_irq_pkg::ADDR_MASK)) begin
            rd_data = {28'h0, mask_r};
        end else begin
            rd_mapped = 1'h0;
        end
    end

    // Read data and error are captured together with pready so that all
    // three leave the block from flip-flops in the same cycle.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata_r <= 32'h0;
            pslverr_r <= 1'h0;
        end else begin
            if (access & ~pready_r & ~pwrite) begin
                prdata_r <= rd_data;
            end
            pslverr_r <= access & ~pready_r & ~rd_mapped;
        end
    end

    // Pin inputs cross into the clock domain through two flip-flops; the
    // active level and the edge are judged only on the second stage.
    assign pin_in = {ext_irq1_input, ext_irq0_input};
    assign pol = {cfg_r[timer_irq_pkg::CFG_POL1],
                  cfg_r[timer_irq_pkg::CFG_POL0]};
    assign etype = {ctl_r.ext_irq1_type_select, ctl_r.ext_irq0_type_select};

    for (genvar i = 0; i < 2; i++) begin : g_ext
        // Synchroniser resets high so an idle active-low pin does not fire.
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                sync1_r[i] <= timer_irq_pkg::SYNC_RST;
                sync2_r[i] <= timer_irq_pkg::SYNC_RST;
                active_prev_r[i] <= 1'h0;
            end else begin
                sync1_r[i] <= pin_in[i];
                sync2_r[i] <= sync1_r[i];
                active_prev_r[i] <= active[i];
            end
        end

        // Polarity 1 means active high, 0 means active low.
        assign active[i] = ~(sync2_r[i] ^ pol[i]);
        // Type 1 catches the inactive-to-active edge, type 0 the level.
        assign ext_set[i] = etype[i] ? (active[i] & ~active_prev_r[i])
                                     : active[i];
    end

    // Control register. Hardware sets are applied last, so an event in the
    // cycle of a software or vectoring clear is never lost.
    always_comb begin
        ctl_nxt = ctl_r;
        if (wr_ctl) begin
            ctl_nxt = timer_irq_pkg::ctl_t'(pwdata[7:0]);
        end
        if (vector_ack.timer0) begin
            ctl_nxt.timer0_overflow_flag = 1'h0;
        end
        if (vector_ack.timer1) begin
            ctl_nxt.timer1_overflow_flag = 1'h0;
        end
        // A level-triggered request stays pending through vectoring.
        if (vector_ack.ext0 & ctl_r.ext_irq0_type_select) begin
            ctl_nxt.ext_irq0_pending = 1'h0;
        end
        if (vector_ack.ext1 & ctl_r.ext_irq1_type_select) begin
            ctl_nxt.ext_irq1_pending = 1'h0;
        end
        if (timer0_rollover) begin
            ctl_nxt.timer0_overflow_flag = 1'h1;
        end
        if (timer1_rollover) begin
            ctl_nxt.timer1_overflow_flag = 1'h1;
        end
        if (ext_set[0]) begin
            ctl_nxt.ext_irq0_pending = 1'h1;
        end
        if (ext_set[1]) begin
            ctl_nxt.ext_irq1_pending = 1'h1;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctl_r <= timer_irq_pkg::CTL_RST;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // Polarity config register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= timer_irq_pkg::CFG_RST;
        end else if (wr_en & hit(paddr, timer_irq_pkg::ADDR_CFG)) begin
            cfg_r <= pwdata[1:0];
        end
    end

    // Sticky event status, write one to clear; a new event wins the clear.
    always_comb begin
        events = 4'h0;
        events[timer_irq_pkg::EV_TIMER0] = timer0_rollover;
        events[timer_irq_pkg::EV_TIMER1] = timer1_rollover;
        events[timer_irq_pkg::EV_EXT0] = ext_set[0];
        events[timer_irq_pkg::EV_EXT1] = ext_set[1];
        status_nxt = status_r;
        if (wr_en & hit(paddr, timer_irq_pkg::ADDR_STATUS)) begin
            status_nxt = status_r & ~pwdata[3:0];
        end
        status_nxt = status_nxt | events;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            status_r <= timer_irq_pkg::STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Mask register and interrupt line. The line is registered, so it lags
    // the status bit by one cycle; this keeps the output glitch free.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask_r <= timer_irq_pkg::MASK_RST;
        end else if (wr_en & hit(paddr, timer_irq_pkg::ADDR_MASK)) begin
            mask_r <= pwdata[3:0];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_r <= 1'h0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

    // Outputs, all straight from flip-flops.
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign timer0_run = ctl_r.timer0_run;
    assign timer1_run = ctl_r.timer1_run;
    assign ctl_flags = ctl_r;
    assign irq = irq_r;

    // Checks on the behaviour above.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_wr_ctl;
        wr_ctl;
    endsequence

    sequence s_rise1;
        active[1] && !active_prev_r[1] && ctl_r.ext_irq1_type_select;
    endsequence

    property p_t0_set;
        timer0_rollover |=> ctl_flags.timer0_overflow_flag;
    endproperty
    a_t0_set: assert property (p_t0_set) else $error("t0 flag not set");

    property p_t0_vec;
        vector_ack.timer0 && !timer0_rollover
            |=> !ctl_flags.timer0_overflow_flag;
    endproperty
    a_t0_vec: assert property (p_t0_vec) else $error("t0 flag kept");

    property p_t0_run;
        s_wr_ctl ##1 !wr_ctl |-> timer0_run == $past(pwdata[4]);
    endproperty
    a_t0_run: assert property (p_t0_run) else $error("t0 run wrong");

    property p_x1_edge;
        s_rise1 |=> ctl_flags.ext_irq1_pending;
    endproperty
    a_x1_edge: assert property (p_x1_edge) else $error("x1 edge lost");

    property p_x1_vec;
        vector_ack.ext1 && ctl_r.ext_irq1_type_select && !ext_set[1]
            |=> !ctl_flags.ext_irq1_pending;
    endproperty
    a_x1_vec: assert property (p_x1_vec) else $error("x1 not cleared");

    property p_x0_vec;
        vector_ack.ext0 && ctl_r.ext_irq0_type_select && !ext_set[0]
            |=> !ctl_flags.ext_irq0_pending;
    endproperty
    a_x0_vec: assert property (p_x0_vec) else $error("x0 not cleared");

    property p_x1_level;
        !ctl_r.ext_irq1_type_select && active[1]
            |=> ctl_flags.ext_irq1_pending;
    endproperty
    a_x1_level: assert property (p_x1_level) else $error("x1 level");

    property p_x1_pol;
        !ctl_r.ext_irq1_type_select && !cfg_r[timer_irq_pkg::CFG_POL1]
            && !sync2_r[1] |=> ctl_flags.ext_irq1_pending;
    endproperty
    a_x1_pol: assert property (p_x1_pol) else $error("x1 polarity");

    property p_x0_level;
        !ctl_r.ext_irq0_type_select && active[0]
            |=> ctl_flags.ext_irq0_pending;
    endproperty
    a_x0_level: assert property (p_x0_level) else $error("x0 level");

    property p_t1_set;
        timer1_rollover |=> ctl_flags.timer1_overflow_flag;
    endproperty
    a_t1_set: assert property (p_t1_set) else $error("t1 flag not set");

    property p_t1_run;
        s_wr_ctl ##1 !wr_ctl |-> timer1_run == $past(pwdata[6]);
    endproperty
    a_t1_run: assert property (p_t1_run) else $error("t1 run wrong");

    property p_apb_ready;
        access && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("pready late");

endmodule : timer_and_ext_irq_control

// File: hw/timer_irq_pkg.sv
// Constants, register layout and carrier types of the timer control bank.
// Notes on behaviour
// - Timer 0 rollover sets the timer 0 overflow flag to 1.
// - Software may clear timer 0 overflow flag; vectoring also clears it.
// - Timer 0 counts while its run bit is 1 and stops when 0.
// - Ext irq 1 pending sets on the edge or level chosen by its type bit.
// - Software clears ext irq 1 pending; vectoring clears it in edge mode.
// - Ext irq 0 pending: set on detect, software clear, edge-mode vector clear.
// - Ext irq 1 is level triggered with type bit 0, edge triggered with 1.
// - Ext irq 1 active sense comes from a polarity bit in the config register
// - Ext irq 0 is level triggered with type bit 0, edge triggered with 1.
package timer_irq_pkg;

    // Byte addresses of the registers on the APB.
    localparam logic [7:0] ADDR_CTL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;

    // Positions of the polarity bits in the config register.
    localparam int CFG_POL0 = 0;
    localparam int CFG_POL1 = 1;

    // Positions of the events in the sticky status and mask registers.
    localparam int EV_TIMER0 = 0;
    localparam int EV_TIMER1 = 1;
    localparam int EV_EXT0 = 2;
    localparam int EV_EXT1 = 3;

    // Values after reset.
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic SYNC_RST = 1'h1;

    // Control and status register, bit 7 first.
    typedef struct packed {
        logic timer1_overflow_flag;
        logic timer1_run;
        logic timer0_overflow_flag;
        logic timer0_run;
        logic ext_irq1_pending;
        logic ext_irq1_type_select;
        logic ext_irq0_pending;
        logic ext_irq0_type_select;
    } ctl_t;

    // One-cycle acknowledges from the CPU when it vectors to a routine.
    typedef struct packed {
        logic timer1;
        logic ext1;
        logic timer0;
        logic ext0;
    } vector_ack_t;

endpackage : timer_irq_pkg

// File: verification/cpu_vector_model.sv
// Behavioural CPU that vectors to pending service routines.
`timescale 1ns/1ps
module cpu_vector_model (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Flags seen by the CPU and the routines it may enter.
    input wire timer_irq_pkg::ctl_t ctl_flags,
    input wire logic [3:0] enable,
    input wire logic [3:0] lag,
    // One-cycle vector acknowledges.
    output timer_irq_pkg::vector_ack_t vector_ack
);
    logic [3:0] wait_r;
    logic [3:0] want;

    // Enabled pending sources in acknowledge bit order.
    assign want = {ctl_flags.timer1_overflow_flag, ctl_flags.ext_irq1_pending,
        ctl_flags.timer0_overflow_flag, ctl_flags.ext_irq0_pending} & enable;

    // Waits lag cycles, then enters one routine, lowest bit first.
    // The idle cycle after each acknowledge lets the flag clear first.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 4'h0;
            vector_ack <= '0;
        end else if (vector_ack != '0 || want == 4'h0) begin
            wait_r <= 4'h0;
            vector_ack <= '0;
        end else if (wait_r < lag) begin
            wait_r <= wait_r + 4'h1;
        end else begin
            vector_ack <= timer_irq_pkg::vector_ack_t'(want & (~want + 4'h1));
        end
    end
endmodule : cpu_vector_model

// File: verification/test_timer_and_ext_irq_control.sv
// Self-checking bench for the timer and ext-irq control bank.
`timescale 1ns/1ps
module test_timer_and_ext_irq_control;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] roll = 2'h0;
    logic [1:0] pin = 2'h3;
    logic [3:0] svc = 4'h0;
    logic [3:0] lag = 4'h0;
    logic [1:0] runs;
    logic irq;
    timer_irq_pkg::vector_ack_t ack;
    timer_irq_pkg::ctl_t flags;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int samples_checked = 0;

    // The 25 MHz system clock.
    always #20 clock = ~clock;

    // Device under test and the CPU on its vector side.
    timer_and_ext_irq_control i_dut (.clock(clock), .nrst(nrst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer0_rollover(roll[0]),
        .timer1_rollover(roll[1]), .timer0_run(runs[0]),
        .timer1_run(runs[1]), .ext_irq0_input(pin[0]),
        .ext_irq1_input(pin[1]), .vector_ack(ack), .ctl_flags(flags),
        .irq(irq));
    cpu_vector_model i_cpu (.clock(clock), .nrst(nrst), .ctl_flags(flags),
        .enable(svc), .lag(lag), .vector_ack(ack));

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Compares one value; unknown bits never match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    // Waits a number of clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    // One APB transfer; the wait for pready is bounded.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: no pready", $time);
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reads a register and compares it.
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    // Compares the control register as the CPU sees it.
    task automatic flg(input logic [7:0] e);
        chk({24'h0, flags}, {24'h0, e});
    endtask : flg

    // One-cycle rollover pulse on timer i.
    task automatic pulse(input int i);
        roll[i] <= 1'b1;
        @(posedge clock);
        roll <= 2'h0;
    endtask : pulse

    // Main sequence; pins idle high, which is inactive after reset.
    initial begin
        tick(8);
        nrst <= 1'b1;
        rdchk(timer_irq_pkg::ADDR_CTL, 32'h0);
        rdchk(timer_irq_pkg::ADDR_CFG, 32'h0);
        rdchk(timer_irq_pkg::ADDR_STATUS, 32'h0);
        rdchk(timer_irq_pkg::ADDR_MASK, 32'h0);
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h50);
        tick(1);
        chk({30'h0, runs}, 32'h3);
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h10);
        tick(1);
        chk({30'h0, runs}, 32'h1);
        apb(1'b1, timer_irq_pkg::ADDR_MASK, 32'h1);
        // Timer 0 flag, then a slow vector clears it.
        pulse(0);
        tick(3);
        flg(8'h30);
        chk({31'h0, irq}, 32'h1);
        rdchk(timer_irq_pkg::ADDR_STATUS, 32'h1);
        lag <= 4'h3;
        svc <= 4'h2;
        tick(8);
        svc <= 4'h0;
        flg(8'h10);
        apb(1'b1, timer_irq_pkg::ADDR_STATUS, 32'hF);
        tick(3);
        chk({31'h0, irq}, 32'h0);
        pulse(0);
        tick(2);
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h00);
        tick(1);
        flg(8'h00);
        // Timer 1 flag with a prompt vector.
        pulse(1);
        tick(2);
        flg(8'h80);
        lag <= 4'h0;
        svc <= 4'h8;
        tick(4);
        svc <= 4'h0;
        flg(8'h00);
        // Ext 0 edge mode, then level mode, active low; in edge mode a held pin does not retrigger.
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h01);
        pin[0] <= 1'b0;
        tick(5);
        flg(8'h03);
        svc <= 4'h1;
        tick(4);
        svc <= 4'h0;
        tick(3);
        flg(8'h01);
        pin[0] <= 1'b1;
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h00);
        tick(3);
        pin[0] <= 1'b0;
        tick(5);
        flg(8'h02);
        pin[0] <= 1'b1;
        tick(4);
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h00);
        tick(1);
        flg(8'h00);
        // Ext 1 level mode made active high by its polarity bit.
        // The low pin still counts as active until the new polarity lands,
        // so the pending flag it leaves behind is cleared before the check.
        pin[1] <= 1'b0;
        apb(1'b1, timer_irq_pkg::ADDR_CFG, 32'h2);
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h00);
        tick(4);
        flg(8'h00);
        pin[1] <= 1'b1;
        tick(5);
        flg(8'h08);
        svc <= 4'h4;
        tick(6);
        svc <= 4'h0;
        flg(8'h08);
        pin[1] <= 1'b0;
        tick(4);
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h00);
        tick(1);
        flg(8'h00);
        // Ext 1 edge mode, rising edge.
        apb(1'b1, timer_irq_pkg::ADDR_CTL, 32'h04);
        pin[1] <= 1'b1;
        tick(5);
        flg(8'h0C);
        svc <= 4'h4;
        tick(4);
        svc <= 4'h0;
        flg(8'h04);
        // Unmapped address is refused; config keeps its value.
        apb(1'b1, 8'h10, 32'hFF);
        chk({31'h0, err}, 32'h1);
        rdchk(8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        rdchk(timer_irq_pkg::ADDR_CFG, 32'h2);
        report_and_stop();
    end
endmodule : test_timer_and_ext_irq_control
